/* hdl/mrap_regs.vh */
// Register map, field positions and reset values of the register access port.
// Assumes inclusion by the port module only; holds definitions alone.
`ifndef MRAP_REGS_VH
`define MRAP_REGS_VH
// Register addresses in the six-bit target_register_field.
`define MRAP_A_AE_TOT 6'h01
`define MRAP_A_AE_COR 6'h02
`define MRAP_A_AE_LINE 6'h03
`define MRAP_A_VA_TOT 6'h04
`define MRAP_A_VA_COR 6'h05
`define MRAP_A_VA_LINE 6'h06
`define MRAP_A_PERIOD 6'h07
`define MRAP_A_MEAS_CFG 6'h0B
`define MRAP_A_ACT_CFG 6'h0D
`define MRAP_A_APP_CFG 6'h0E
`define MRAP_A_IRQ_EN 6'h0F
`define MRAP_A_IRQ_FLAGS 6'h10
`define MRAP_A_IRQ_COR 6'h11
`define MRAP_A_HALF_CYC 6'h13
// Command byte fields.
`define MRAP_CMD_WR_BIT 7
`define MRAP_CMD_ADDR_HI 5
// Reset values of the writable registers.
`define MRAP_RST_MEAS_CFG 8'h70
`define MRAP_RST_ACT_CFG 8'h3F
`define MRAP_RST_APP_CFG 8'h3F
`define MRAP_RST_IRQ_EN 16'h0000
`define MRAP_RST_HALF_CYC 16'hFFFF
// Configuration field positions (phase masks and period channel).
`define MRAP_TOT_MASK_HI 5
`define MRAP_TOT_MASK_LO 3
`define MRAP_LINE_MASK_HI 2
`define MRAP_LINE_MASK_LO 0
`define MRAP_PER_SEL_HI 1
`define MRAP_PER_SEL_LO 0
// Interrupt flag raised when a line-cycle accumulation completes.
`define MRAP_FLG_LINE 2
`endif

/* hdl/mrap_port.v */
// Serial register access port of a polyphase energy meter, with the energy
// accumulators, line period estimate and interrupt flags behind it.
// Assumes power samples, zero-crossing pulses and events arrive on core_clk;
// serial pins come from the host and are synchronised here.
`timescale 1ns/1ps
`include "mrap_regs.vh"

module mrap_port #(
    parameter PW = 16
) (
    // Clock and reset.
    input wire core_clk,
    input wire reset,
    // Serial pins from the host.
    input wire sclk,
    input wire cs_n,
    input wire din,
    // Serial data output with its enable.
    output reg dout,
    output reg dout_oe,
    // Open-drain interrupt pin, active low.
    output reg irq_n_o,
    output reg irq_n_oe,
    // Measurement inputs, phase a in the low slice.
    input wire [3*PW-1:0] act_pwr,
    input wire [3*PW-1:0] app_pwr,
    input wire pwr_valid,
    input wire [2:0] zero_cross,
    input wire [15:0] irq_event
);

    localparam ST_CMD = 2'b00;
    localparam ST_RD = 2'b01;
    localparam ST_WR = 2'b10;

    // Sum of the phases chosen by a three-bit mask.
    function [23:0] sel_sum;
        input [2:0] mask;
        input [3*PW-1:0] pw;
        integer i;
        begin
            sel_sum = 24'h000000;
            for (i = 0; i < 3; i = i + 1) begin
                if (mask[i]) begin
                    sel_sum = sel_sum + {{(24-PW){1'b0}}, pw[i*PW +: PW]};
                end
            end
        end
    endfunction
    // Byte length of each register.
    function [1:0] reg_bytes;
        input [5:0] a;
        begin
            if (a >= `MRAP_A_AE_TOT && a <= `MRAP_A_VA_LINE) begin
                reg_bytes = 2'd3;
            end else if (a == `MRAP_A_PERIOD || a == `MRAP_A_IRQ_EN ||
                         a == `MRAP_A_IRQ_FLAGS || a == `MRAP_A_IRQ_COR ||
                         a == `MRAP_A_HALF_CYC) begin
                reg_bytes = 2'd2;
            end else begin
                reg_bytes = 2'd1;
            end
        end
    endfunction

    reg sclk_s1_r, sclk_s2_r, sclk_s3_r;
    reg cs_s1_r, cs_s2_r, din_s1_r, din_s2_r;
    reg hold_r, rd_done_r, line_evt_r;
    reg [1:0] state_r, nb;
    reg [4:0] cnt_r, nbits_r;
    reg [6:0] cmd_sh_r;
    reg [5:0] addr_r, done_addr_r;
    reg [7:0] meas_cfg_r, act_cfg_r, app_cfg_r;
    reg [14:0] per_cnt_r, period_r;
    reg [15:0] irq_en_r, half_cyc_r, flags_r, hc_cnt_r;
    reg [23:0] rd_sh_r, wr_sh_r, snap_r, rd_val;
    reg [23:0] ae_acc_r, va_acc_r, la_acc_r, lva_acc_r;
    reg [23:0] ae_line_r, va_line_r;
    wire sclk_rise = sclk_s2_r & ~sclk_s3_r;
    wire sclk_fall = ~sclk_s2_r & sclk_s3_r;
    wire [7:0] cmd_byte = {cmd_sh_r, din_s2_r};
    wire [5:0] cmd_addr = cmd_byte[`MRAP_CMD_ADDR_HI:0];
    wire last_bit = (cnt_r == nbits_r - 5'd1);
    wire zx_any = |zero_cross;

    // Two-stage synchronisers; the third sclk stage only feeds edge finding.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sclk_s1_r <= 1'b1;
            sclk_s2_r <= 1'b1;
            sclk_s3_r <= 1'b1;
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            din_s1_r <= 1'b0;
            din_s2_r <= 1'b0;
        end else begin
            sclk_s1_r <= sclk;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            din_s1_r <= din;
            din_s2_r <= din_s1_r;
        end
    end

    // Read multiplexer over the whole map; unmapped addresses read zero.
    always @* begin
        rd_val = 24'h000000;
        case (cmd_addr)
            `MRAP_A_AE_TOT: rd_val = ae_acc_r;
            `MRAP_A_AE_COR: rd_val = ae_acc_r;
            `MRAP_A_AE_LINE: rd_val = ae_line_r;
            `MRAP_A_VA_TOT: rd_val = va_acc_r;
            `MRAP_A_VA_COR: rd_val = va_acc_r;
            `MRAP_A_VA_LINE: rd_val = va_line_r;
            `MRAP_A_PERIOD: rd_val = {9'h000, period_r};
            `MRAP_A_MEAS_CFG: rd_val = {16'h0000, meas_cfg_r};
            `MRAP_A_ACT_CFG: rd_val = {16'h0000, act_cfg_r};
            `MRAP_A_APP_CFG: rd_val = {16'h0000, app_cfg_r};
            `MRAP_A_IRQ_EN: rd_val = {8'h00, irq_en_r};
            `MRAP_A_IRQ_FLAGS: rd_val = {8'h00, flags_r};
            `MRAP_A_IRQ_COR: rd_val = {8'h00, flags_r};
            `MRAP_A_HALF_CYC: rd_val = {8'h00, half_cyc_r};
            default: rd_val = 24'h000000;
        endcase
        nb = reg_bytes(cmd_addr);
    end

    // Serial engine: command byte, then one data transfer, then command again.
    // Deselect at any time abandons the transfer and floats the output.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_r <= ST_CMD;
            cnt_r <= 5'd0;
            nbits_r <= 5'd8;
            cmd_sh_r <= 7'h00;
            addr_r <= 6'h00;
            rd_sh_r <= 24'h000000;
            wr_sh_r <= 24'h000000;
            snap_r <= 24'h000000;
            hold_r <= 1'b0;
            rd_done_r <= 1'b0;
            done_addr_r <= 6'h00;
            dout <= 1'b0;
            dout_oe <= 1'b0;
            meas_cfg_r <= `MRAP_RST_MEAS_CFG;
            act_cfg_r <= `MRAP_RST_ACT_CFG;
            app_cfg_r <= `MRAP_RST_APP_CFG;
            irq_en_r <= `MRAP_RST_IRQ_EN;
            half_cyc_r <= `MRAP_RST_HALF_CYC;
        end else begin
            rd_done_r <= 1'b0;
            if (cs_s2_r) begin
                state_r <= ST_CMD;
                cnt_r <= 5'd0;
                dout_oe <= 1'b0;
                hold_r <= 1'b0;
            end else begin
                case (state_r)
                    ST_CMD: begin
                        if (sclk_fall) begin
                            cmd_sh_r <= cmd_byte[6:0];
                            cnt_r <= cnt_r + 5'd1;
                            if (cnt_r == 5'd7) begin
                                cnt_r <= 5'd0;
                                addr_r <= cmd_addr;
                                nbits_r <= {nb, 3'b000};
                                // Bit six is ignored.
                                if (cmd_byte[`MRAP_CMD_WR_BIT]) begin
                                    state_r <= ST_WR;
                                end else begin
                                    state_r <= ST_RD;
                                    // Whole-register snapshot.
                                    snap_r <= rd_val;
                                    case (nb)
                                        2'd3: rd_sh_r <= rd_val;
                                        2'd2: rd_sh_r <= {rd_val[15:0],
                                                          8'h00};
                                        default: rd_sh_r <= {rd_val[7:0],
                                                             16'h0000};
                                    endcase
                                    if (cmd_addr == `MRAP_A_IRQ_FLAGS ||
                                        cmd_addr == `MRAP_A_IRQ_COR) begin
                                        hold_r <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                    ST_RD: begin
                        if (sclk_rise) begin
                            dout <= rd_sh_r[23];
                            dout_oe <= 1'b1;
                            rd_sh_r <= {rd_sh_r[22:0], 1'b0};
                        end
                        if (sclk_fall) begin
                            cnt_r <= cnt_r + 5'd1;
                            if (last_bit) begin
                                state_r <= ST_CMD;
                                cnt_r <= 5'd0;
                                dout_oe <= 1'b0;
                                hold_r <= 1'b0;
                                rd_done_r <= 1'b1;
                                done_addr_r <= addr_r;
                            end
                        end
                    end
                    ST_WR: begin
                        if (sclk_fall) begin
                            // Shifting in from the right leaves short
                            // registers right justified.
                            wr_sh_r <= {wr_sh_r[22:0], din_s2_r};
                            cnt_r <= cnt_r + 5'd1;
                            if (last_bit) begin
                                state_r <= ST_CMD;
                                cnt_r <= 5'd0;
                                case (addr_r)
                                    `MRAP_A_MEAS_CFG:
                                        meas_cfg_r <= {wr_sh_r[6:0], din_s2_r};
                                    `MRAP_A_ACT_CFG:
                                        act_cfg_r <= {wr_sh_r[6:0], din_s2_r};
                                    `MRAP_A_APP_CFG:
                                        app_cfg_r <= {wr_sh_r[6:0], din_s2_r};
                                    `MRAP_A_IRQ_EN:
                                        irq_en_r <= {wr_sh_r[14:0], din_s2_r};
                                    `MRAP_A_HALF_CYC:
                                        half_cyc_r <= {wr_sh_r[14:0],
                                                       din_s2_r};
                                    default: ;
                                endcase
                            end
                        end
                    end
                    default: state_r <= ST_CMD;
                endcase
            end
        end
    end

    // Energy accumulators. A clear-on-read subtracts the value handed out
    // instead of zeroing, so samples landing during the read are kept.
    wire clr_ae = rd_done_r && done_addr_r == `MRAP_A_AE_COR;
    wire clr_va = rd_done_r && done_addr_r == `MRAP_A_VA_COR;
    wire [23:0] ae_add = pwr_valid ? sel_sum(act_cfg_r[`MRAP_TOT_MASK_HI:
        `MRAP_TOT_MASK_LO], act_pwr) : 24'h000000;
    wire [23:0] va_add = pwr_valid ? sel_sum(app_cfg_r[`MRAP_TOT_MASK_HI:
        `MRAP_TOT_MASK_LO], app_pwr) : 24'h000000;
    wire [23:0] la_add = pwr_valid ? sel_sum(act_cfg_r[`MRAP_LINE_MASK_HI:
        `MRAP_LINE_MASK_LO], act_pwr) : 24'h000000;
    wire [23:0] lva_add = pwr_valid ? sel_sum(app_cfg_r[`MRAP_LINE_MASK_HI:
        `MRAP_LINE_MASK_LO], app_pwr) : 24'h000000;
    wire hc_end = zx_any && (hc_cnt_r + 16'd1 >= half_cyc_r);
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ae_acc_r <= 24'h000000;
            va_acc_r <= 24'h000000;
            la_acc_r <= 24'h000000;
            lva_acc_r <= 24'h000000;
            ae_line_r <= 24'h000000;
            va_line_r <= 24'h000000;
            hc_cnt_r <= 16'h0000;
            line_evt_r <= 1'b0;
        end else begin
            ae_acc_r <= ae_acc_r - (clr_ae ? snap_r : 24'h0) + ae_add;
            va_acc_r <= va_acc_r - (clr_va ? snap_r : 24'h0) + va_add;
            line_evt_r <= hc_end;
            if (hc_end) begin
                ae_line_r <= la_acc_r + la_add;
                va_line_r <= lva_acc_r + lva_add;
                la_acc_r <= 24'h000000;
                lva_acc_r <= 24'h000000;
                hc_cnt_r <= 16'h0000;
            end else begin
                la_acc_r <= la_acc_r + la_add;
                lva_acc_r <= lva_acc_r + lva_add;
                if (zx_any) begin
                    hc_cnt_r <= hc_cnt_r + 16'd1;
                end
            end
        end
    end

    // Period counter on the chosen phase; saturates when crossings stop.
    wire [1:0] per_sel = meas_cfg_r[`MRAP_PER_SEL_HI:`MRAP_PER_SEL_LO];
    wire per_zx = zero_cross[(per_sel == 2'd3) ? 2'd0 : per_sel];
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            per_cnt_r <= 15'h0000;
            period_r <= 15'h0000;
        end else if (per_zx) begin
            period_r <= per_cnt_r;
            per_cnt_r <= 15'h0001;
        end else if (per_cnt_r != 15'h7FFF) begin
            per_cnt_r <= per_cnt_r + 15'h0001;
        end
    end

    // Flags set regardless of enables; a new event beats the read clear.
    wire clr_flags = rd_done_r && done_addr_r == `MRAP_A_IRQ_COR;
    wire [15:0] new_ev = irq_event |
                         ({15'h0000, line_evt_r} << `MRAP_FLG_LINE);
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            flags_r <= 16'h0000;
            irq_n_o <= 1'b0;
            irq_n_oe <= 1'b0;
        end else begin
            flags_r <= new_ev |
                (flags_r & ~(clr_flags ? snap_r[15:0] : 16'h0000));
            irq_n_o <= 1'b0;
            // Pull low only for enabled flags and never while held.
            irq_n_oe <= (|(flags_r & irq_en_r)) & ~hold_r;
        end
    end

endmodule // mrap_port

/* testbench/mrap_port_sva.sv */
// Checker for the serial port pins and the interrupt pin.
// Assumes sclk, cs_n and din change just after core_clk edges.
`timescale 1ns/1ps
module mrap_port_sva (
    // Clock and reset.
    input wire core_clk,
    input wire reset,
    // Serial and interrupt pins.
    input wire sclk,
    input wire cs_n,
    input wire din,
    input wire dout,
    input wire dout_oe,
    input wire irq_n_o,
    input wire irq_n_oe
);
    reg sclk_q;
    reg [4:0] cnt;
    reg [6:0] sh;
    reg st_r;
    reg rd_r;
    reg wr_r;
    reg [3:0] age;
    wire fall = sclk_q && !sclk;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // Decode each command byte; cs_n high ends every transfer here.
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sclk_q <= 1'b1;
            cnt <= 5'h00;
            sh <= 7'h00;
            {st_r, rd_r, wr_r} <= 3'h0;
            age <= 4'hF;
        end else begin
            sclk_q <= sclk;
            age <= (sclk && !sclk_q) ? 4'h0 : age + {3'h0, age != 4'hF};
            if (cs_n) begin
                cnt <= 5'h00;
                {st_r, rd_r, wr_r} <= 3'h0;
            end else if (fall) begin
                cnt <= cnt + 5'h01;
                sh <= {sh[5:0], din};
                if (cnt == 5'h07) begin
                    rd_r <= !sh[6];
                    wr_r <= sh[6];
                    // Bits five to one of 010000 pick address 10h or 11h.
                    st_r <= !sh[6] && (sh[4:0] == 5'h08);
                end
            end
        end
    end
    reset_quiet_a: assert property (disable iff (1'b0)
        reset |=> !dout_oe && !irq_n_oe) else $error("pins active in reset");
    od_level_a: assert property (
        !irq_n_o) else $error("interrupt pin drives high");
    oe_after_read_a: assert property (
        $rose(dout_oe) |-> rd_r && cnt inside {[8:9]})
        else $error("dout driven outside read data");
    oe_abort_a: assert property (
        $rose(cs_n) |-> ##[0:6] !dout_oe) else $error("dout kept after cs_n");
    dout_edge_a: assert property (
        dout_oe && $past(dout_oe) && $changed(dout) |-> age inside {[1:6]})
        else $error("dout moved away from sclk rise");
    write_quiet_a: assert property (
        wr_r |-> !dout_oe) else $error("dout driven during write");
    irq_release_a: assert property (
        $rose(st_r) |-> ##[0:5] !irq_n_oe)
        else $error("interrupt not released");
    irq_hold_a: assert property (
        st_r && cnt inside {[9:23]} |-> !irq_n_oe)
        else $error("interrupt reasserted in status data");
endmodule // mrap_port_sva

/* testbench/mrap_host.sv */
// Host model: serial master, sclk idles high, 80 ns bit period.
// Assumes core_clk at 100 MHz; the bench calls xfer between transfers.
`timescale 1ns/1ps
module mrap_host (
    // Clock.
    input wire core_clk,
    // Serial pins.
    output reg sclk,
    output reg cs_n,
    output reg din,
    input wire dout,
    input wire dout_oe
);
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
    end
    // One command byte then nbits of data, MSB first, right justified.
    task automatic xfer(input [7:0] cmd, input integer nbits,
                        input [23:0] wd, output [23:0] rd);
        reg [31:0] sh;
        reg prev;
        integer i;
        begin
            sh = {cmd[7], 1'b0, cmd[5:0],
                  wd << (24 - nbits)};
            rd = 24'h000000;
            prev = 1'b0;
            @(posedge core_clk);
            cs_n <= 1'b0;
            repeat (3) @(posedge core_clk);
            // Data is set up half a bit before the fall that samples it.
            for (i = 0; i < 8 + nbits; i = i + 1) begin
                din <= sh[31 - i];
                repeat (4) @(posedge core_clk);
                sclk <= 1'b0;
                repeat (2) @(posedge core_clk);
                #1 prev = dout_oe ? dout : ~prev;
                if (i >= 8) rd = {rd[22:0], prev};
                repeat (2) @(posedge core_clk);
                sclk <= 1'b1;
            end
            repeat (4) @(posedge core_clk);
            cs_n <= 1'b1;
            din <= ~din; // Released line shows no stale value.
            repeat (8) @(posedge core_clk);
        end
    endtask
endmodule // mrap_host

/* testbench/tb.sv */
// Bench for the register access port: register reads and writes, energy,
// line cycles, period and interrupts. Assumes the host model drives pins.
`timescale 1ns/1ps
module tb;
    reg core_clk = 1'b0;
    reg reset = 1'b1;
    reg [47:0] act_pwr = {16'h0003, 16'h0002, 16'h0001};
    reg [47:0] app_pwr = {16'h001E, 16'h0014, 16'h000A};
    reg pwr_valid = 1'b0;
    reg [2:0] zero_cross = 3'h0;
    reg [15:0] irq_event = 16'h0000;
    wire sclk, cs_n, din, dout, dout_oe, irq_n_o, irq_n_oe;
    wire irq_line = irq_n_oe ? irq_n_o : 1'b1; // Pull-up on the pin.
    integer miscompares = 0;
    integer tests_run = 0;
    integer a;
    reg [23:0] rd;
    always #5 core_clk = ~core_clk;
    mrap_port #(.PW(16)) mrap_port_i (.core_clk(core_clk), .reset(reset),
        .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout), .dout_oe(dout_oe),
        .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe), .act_pwr(act_pwr),
        .app_pwr(app_pwr), .pwr_valid(pwr_valid), .zero_cross(zero_cross),
        .irq_event(irq_event));
    mrap_host mrap_host_i (.core_clk(core_clk), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe));
    task check(input [23:0] seen, input [23:0] exp);
        begin
            tests_run = tests_run + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch at %0t: saw %h expected %h", $time,
                         seen, exp);
            end
        end
    endtask
    // Data length of each address; unmapped ones give one byte.
    function integer nb(input [5:0] ad);
        case (ad)
            6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06: nb = 24;
            6'h07, 6'h0F, 6'h10, 6'h11, 6'h13: nb = 16;
            default: nb = 8;
        endcase
    endfunction
    function [23:0] rst_val(input [5:0] ad);
        case (ad)
            6'h0B: rst_val = 24'h000070;
            6'h0D, 6'h0E: rst_val = 24'h00003F;
            6'h13: rst_val = 24'h00FFFF;
            default: rst_val = 24'h000000;
        endcase
    endfunction
    task rd_chk(input [5:0] ad, input [23:0] exp);
        begin
            mrap_host_i.xfer({2'b00, ad}, nb(ad), 24'h000000, rd);
            check(rd, exp);
        end
    endtask
    task wr(input [5:0] ad, input [23:0] v);
        mrap_host_i.xfer({2'b10, ad}, nb(ad), v, rd);
    endtask
    task sample;
        begin
            @(posedge core_clk) pwr_valid <= 1'b1;
            @(posedge core_clk) pwr_valid <= 1'b0;
        end
    endtask
    task zc;
        begin
            @(posedge core_clk) zero_cross <= 3'h1;
            @(posedge core_clk) zero_cross <= 3'h0;
        end
    endtask
    task close_out;
        begin
            $display("comparisons %0d, mismatches %0d", tests_run,
                     miscompares);
            if (miscompares == 0 && tests_run > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    // Hang guard, well beyond the roughly 9300 cycles the tests take.
    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares = miscompares + 1;
        close_out;
    end
    // Main sequence; sums are 6 active and 60 apparent per sample.
    initial begin
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(posedge core_clk);
        for (a = 1; a < 20; a = a + 1) begin
            rd_chk(a[5:0], rst_val(a[5:0]));
        end
        wr(6'h01, 24'h123456);
        rd_chk(6'h01, 24'h000000);
        wr(6'h13, 24'h000002);
        repeat (3) sample;
        rd_chk(6'h01, 24'd18);
        rd_chk(6'h01, 24'd18);
        rd_chk(6'h02, 24'd18);
        rd_chk(6'h01, 24'd0);
        rd_chk(6'h04, 24'd180);
        rd_chk(6'h05, 24'd180);
        rd_chk(6'h04, 24'd0);
        wr(6'h0D, 24'h000007);
        wr(6'h0E, 24'h000038);
        rd_chk(6'h0D, 24'h000007);
        sample;
        rd_chk(6'h01, 24'd0);
        rd_chk(6'h04, 24'd60);
        wr(6'h0B, 24'h000003);
        wr(6'h0F, 24'h000004);
        @(posedge core_clk) irq_event <= 16'h0020;
        @(posedge core_clk) irq_event <= 16'h0000;
        repeat (4) @(posedge core_clk);
        check({23'h0, irq_line}, 24'h1);
        zc;
        repeat (98) @(posedge core_clk);
        zc;
        repeat (6) @(posedge core_clk);
        check({23'h0, irq_line}, 24'h0);
        rd_chk(6'h03, 24'd24);
        rd_chk(6'h06, 24'd180);
        rd_chk(6'h07, 24'd100);
        rd_chk(6'h10, 24'h000024);
        check({23'h0, irq_line}, 24'h0);
        rd_chk(6'h11, 24'h000024);
        check({23'h0, irq_line}, 24'h1);
        rd_chk(6'h10, 24'h000000);
        close_out;
    end
endmodule // tb
bind mrap_port mrap_port_sva mrap_port_sva_i (.core_clk(core_clk),
    .reset(reset), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
